/* File: src/wdg_defs.svh */
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

// register map (byte addresses on the plain register port)
`define WDG_ADDR_COUNT      8'hD8
`define WDG_ADDR_STATUS     8'hD9
`define WDG_ADDR_MASK       8'hDA
`define WDG_ADDR_INFO       8'hDB

// watchdog_count_control layout
`define WDG_BIT_ACTIVE      0
`define WDG_BIT_TRIGGER     1
`define WDG_RST_COUNT       8'hFE

// status / mask layout
`define WDG_EV_TIMEOUT      0
`define WDG_EV_TRIGGER      1
`define WDG_EV_FROZEN       2
`define WDG_RST_MASK        8'h00

// one counter stage step is this many internal clock cycles
`define WDG_PRESCALE        12'd3072
// stabilisation delay after a watchdog reset, internal clocks
`define WDG_STAB_CYCLES     12'd2048

`endif

/* File: src/wdg_pkg.sv */
package wdg_pkg;

    typedef enum logic [1:0] {
        WDG_RUN,
        WDG_WAIT,
        WDG_STOP
    } wdg_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wdg_bus_t;

    typedef enum logic [1:0] {
        WDG_ST_RUN,
        WDG_ST_HOLD
    } wdg_state_t;

endpackage : wdg_pkg

/* File: src/wdg_core.sv */
`timescale 1ns/1ps
`include "wdg_defs.svh"
// Operation
// - active counter's top stage (bit 6) dropping to zero asserts internal chip reset
// - software option: inactive until activation bit written one
// - once active, deactivation writes ignored until chip reset
// - hardware option: always active, stop acts as wait, counting goes on
// - external stop control, pin low: stop acts as wait, count continues
// - external stop control, pin high: stop freezes counter, true stop
// - leaving stop by interrupt resumes count from held value
// - any reset loads register with FEh
// - reset-trigger bit going one to zero resets immediately
// - period bits map reversed: bit 7 is counter lsb stage
// - only six low stages set timeout; fires when top stage drops
// - timeout spans 3072 to 196608 clocks in 64 steps
// - watchdog reset restarts chip with stabilisation delay
// - hardware option: activation bit reads one, unwritable
module wdg_core
    import wdg_pkg::*;
#(
    parameter bit HW_ACTIVATION = 1'b0,
    parameter bit EXT_STOP_CTRL = 1'b0,
    parameter int PRESCALE      = `WDG_PRESCALE,
    parameter int STAB_CYCLES   = `WDG_STAB_CYCLES
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_stop_req,
    input  wire logic       i_wake,
    input  wire logic       i_nmi_pin,
    output logic [7:0]      o_rdata,
    output logic            o_chip_reset,
    output logic            o_stop_mode,
    output logic            o_irq
);

    // both counters are 12 bits wide
    if (PRESCALE < 1 || PRESCALE > 4095 || STAB_CYCLES < 1
        || STAB_CYCLES > 4095) begin : g_bad_counts
        $error("wdg_core: counts must fit in 12 bits");
    end

    ////////////////////////////////////////////////////////////////////
    // bus and pin capture

    wdg_bus_t   bus;
    logic       nmi_meta;
    logic       nmi_sync;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            nmi_meta <= 1'b0;
            nmi_sync <= 1'b0;
        end else begin
            nmi_meta <= i_nmi_pin;
            nmi_sync <= nmi_meta;
        end
    end

    // reverse register bits 7..1 into counter order (stage 0 = lsb)
    function automatic logic [6:0] reg_to_cnt(input logic [7:0] r);
        logic [6:0] c;
        c = '0;
        for (int k = 0; k < 7; k++) begin
            c[k] = r[7-k];
        end
        return c;
    endfunction : reg_to_cnt

    ////////////////////////////////////////////////////////////////////
    // state

    logic [6:0]  count;
    logic        active;
    logic [11:0] pre;
    logic [11:0] stab;
    logic        in_reset;
    wdg_mode_t   mode;
    logic [7:0]  status;
    logic [7:0]  mask;

    wire wr_count  = bus.wr && bus.addr == `WDG_ADDR_COUNT;
    wire wr_status = bus.wr && bus.addr == `WDG_ADDR_STATUS;
    wire wr_mask   = bus.wr && bus.addr == `WDG_ADDR_MASK;

    // hardware option pins activation high; software bit is one-way
    wire is_active = HW_ACTIVATION || active;

    // stop becomes wait while active unless the pin allows a true stop
    wire stop_ok   = !is_active
                   || (EXT_STOP_CTRL && nmi_sync);
    wire frozen    = (mode == WDG_STOP);

    wire [6:0] wr_cnt = reg_to_cnt(bus.wdata);
    wire pre_tick  = (pre == 12'(PRESCALE - 1));
    // the stage at bit 6 dropping to zero ends the period
    wire timeout   = is_active && !frozen && pre_tick && !wr_count
                   && count[6] && (count[5:0] == 6'h00);
    wire trig_drop = wr_count && count[6] && !bus.wdata[`WDG_BIT_TRIGGER]
                   && !in_reset;
    wire fire      = (timeout || trig_drop) && !in_reset;

    wire [7:0] events = {5'h00, frozen, trig_drop, timeout};
    wire [7:0] next_status = (status & ~(wr_status ? bus.wdata : 8'h00))
                           | events;

    wire [7:0] count_reg = {reg_to_cnt({count, 1'b0}),
                            1'b0} | {7'h00, is_active};

    ////////////////////////////////////////////////////////////////////
    // counter and activation

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count  <= 7'h7F;
            active <= 1'b0;
            pre    <= 12'h000;
        end else if (in_reset) begin
            count  <= 7'h7F;
            active <= 1'b0;
            pre    <= 12'h000;
        end else if (wr_count) begin
            count  <= wr_cnt;
            active <= active | bus.wdata[`WDG_BIT_ACTIVE];
            pre    <= 12'h000;
        end else if (!frozen) begin
            pre <= pre_tick ? 12'h000 : pre + 12'h001;
            if (pre_tick)
                count <= count - 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // chip reset with stabilisation delay

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            in_reset     <= 1'b0;
            stab         <= 12'h000;
            o_chip_reset <= 1'b0;
        end else if (fire) begin
            in_reset     <= 1'b1;
            stab         <= 12'(STAB_CYCLES - 1);
            o_chip_reset <= 1'b1;
        end else if (in_reset) begin
            stab         <= stab - 12'h001;
            in_reset     <= (stab != 12'h000);
            o_chip_reset <= (stab != 12'h000);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power mode

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode        <= WDG_RUN;
            o_stop_mode <= 1'b0;
        end else begin
            case (mode)
                WDG_RUN: begin
                    // a reset firing now wins over a stop request
                    if (i_stop_req && !in_reset && !fire) begin
                        mode        <= stop_ok ? WDG_STOP : WDG_WAIT;
                        o_stop_mode <= stop_ok;
                    end
                end
                WDG_WAIT, WDG_STOP: begin
                    if (i_wake || in_reset) begin
                        mode        <= WDG_RUN;
                        o_stop_mode <= 1'b0;
                    end
                end
                default: begin
                    mode        <= WDG_RUN;
                    o_stop_mode <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events, mask, read port

    wire [7:0] rd_mux =
        (bus.addr == `WDG_ADDR_COUNT)  ? count_reg :
        (bus.addr == `WDG_ADDR_STATUS) ? status :
        (bus.addr == `WDG_ADDR_MASK)   ? mask :
        (bus.addr == `WDG_ADDR_INFO)   ? {6'h00, EXT_STOP_CTRL,
                                          HW_ACTIVATION} : 8'h00;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status  <= 8'h00;
            mask    <= `WDG_RST_MASK;
            o_irq   <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            status  <= next_status;          // set wins over clear
            mask    <= wr_mask ? bus.wdata : mask;
            o_irq   <= |(next_status & (wr_mask ? bus.wdata : mask));
            o_rdata <= bus.rd ? rd_mux : 8'h00;
        end
    end

endmodule : wdg_core

/* File: tb/wdg_monitor.sv */
`timescale 1ns/1ps
module wdg_monitor #(
    parameter int PRESCALE    = 3072,
    parameter int STAB_CYCLES = 2048
) (
    input wire logic       i_sys_clk,
    input wire logic       i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic       i_stop_req,
    input wire logic       i_wake,
    input wire logic       i_nmi_pin,
    input wire logic [7:0] o_rdata,
    input wire logic       o_chip_reset,
    input wire logic       o_stop_mode,
    input wire logic       o_irq
);
    localparam int LO = PRESCALE - 1;
    localparam int HI = PRESCALE + 3;
    wire logic        wd;
    logic             act;
    logic      [15:0] hi_cnt;
    assign wd = i_wr && (i_addr == 8'hD8) && !o_chip_reset;
    // act only tracks program writes; any chip reset drops it again
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            act    <= 1'h0;
            hi_cnt <= 16'h0000;
        end else begin
            act    <= !o_chip_reset && (act || (wd && i_wdata[0]));
            hi_cnt <= o_chip_reset ? hi_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    a_timeout_fire: assert property (wd && i_wdata == 8'h03
        |=> !o_chip_reset ##[LO:HI] o_chip_reset) else $error("timeout off");
    a_trigger_drop: assert property ((wd && i_wdata[1]) ##1
        (wd && !i_wdata[1]) |-> ##[1:2] o_chip_reset) else $error("no trig");
    a_reset_span: assert property ($fell(o_chip_reset)
        |-> hi_cnt == STAB_CYCLES) else $error("reset span wrong");
    a_deact_kept: assert property (act && i_rd && i_addr == 8'hD8
        && !o_chip_reset |=> o_rdata[0]) else $error("watchdog disabled");
    a_wait_not_stop: assert property (act && i_stop_req && !i_nmi_pin
        && !$past(i_nmi_pin) && !$past(i_nmi_pin, 2)
        |=> !o_stop_mode [*3]) else $error("stop with pin low");
    a_stop_high_pin: assert property (i_stop_req && i_nmi_pin
        && $past(i_nmi_pin) && $past(i_nmi_pin, 2) && !o_chip_reset
        |=> ##[0:1] o_stop_mode) else $error("no stop with pin high");
    a_frozen_quiet: assert property (o_stop_mode |-> !o_chip_reset)
        else $error("reset while frozen");
    a_stop_leave: assert property (o_stop_mode && i_wake
        |=> ##[0:1] !o_stop_mode) else $error("stop not left");
endmodule : wdg_monitor

bind wdg_core wdg_monitor #(.PRESCALE(PRESCALE), .STAB_CYCLES(STAB_CYCLES))
    i_wdg_monitor (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_stop_req(i_stop_req), .i_wake(i_wake), .i_nmi_pin(i_nmi_pin),
    .o_rdata(o_rdata), .o_chip_reset(o_chip_reset),
    .o_stop_mode(o_stop_mode), .o_irq(o_irq));

/* File: tb/wdg_pin_model.sv */
`timescale 1ns/1ps
module wdg_pin_model (
    input  wire logic i_pull_low,
    output logic      o_nmi_pin
);
    logic drive_oe_n;
    // open drain line: only ever pulled low, the pull-up wins when released
    assign drive_oe_n = !i_pull_low;
    assign o_nmi_pin  = drive_oe_n ? 1'h1 : 1'h0;
endmodule : wdg_pin_model

/* File: tb/wdg_core_tb_top.sv */
`timescale 1ns/1ps
`include "wdg_defs.svh"
module wdg_core_tb_top;
    logic       clk, rstn, wr, rd, stp, wake, pb0_low, rd_d, f;
    logic [7:0] addr, wdata, rdata, v, exp_q[$];
    logic       chip_rst, stop_m, irq;
    wire logic  nmi;
    int         fail_count, n_compared, seed, i;
    wdg_core #(.HW_ACTIVATION(1'h0), .EXT_STOP_CTRL(1'h1), .PRESCALE(4),
        .STAB_CYCLES(3)) i_wdg_core (.i_sys_clk(clk), .i_resetn(rstn),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .i_stop_req(stp), .i_wake(wake), .i_nmi_pin(nmi), .o_rdata(rdata),
        .o_chip_reset(chip_rst), .o_stop_mode(stop_m), .o_irq(irq));
    wdg_pin_model i_wdg_pin_model (.i_pull_low(pb0_low), .o_nmi_pin(nmi));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // strobes stay up at task end so back-to-back cycles never glitch
    task w(input logic [7:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; wr <= 1'h1; rd <= 1'h0; @(posedge clk);
    endtask : w
    task r(input logic [7:0] a, input logic [7:0] e);
        addr <= a; rd <= 1'h1; wr <= 1'h0; exp_q.push_back(e); @(posedge clk);
    endtask : r
    task idle(input int n);
        wr <= 1'h0; rd <= 1'h0; stp <= 1'h0; wake <= 1'h0;
        repeat (n) @(posedge clk);
    endtask : idle
    task wait_rst(output logic seen);
        for (int k = 0; k < 60 && chip_rst !== 1'h1; k++) @(posedge clk);
        seen = chip_rst;
        for (int k = 0; k < 60 && chip_rst !== 1'h0; k++) @(posedge clk);
    endtask : wait_rst
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rd_d) chk(rdata, exp_q.pop_front());
        rd_d <= rd;
    end
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {rstn, wr, rd, stp, wake, pb0_low, rd_d} = 7'h00;
        {addr, wdata} = 16'h0000;
        {fail_count, n_compared, seed} = {32'd0, 32'd0, 32'd3299};
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        r(`WDG_ADDR_COUNT, `WDG_RST_COUNT);
        r(`WDG_ADDR_MASK, 8'h00);
        r(`WDG_ADDR_INFO, 8'h02);
        r(8'hE0, 8'h00);
        w(`WDG_ADDR_MASK, 8'h04);
        idle(1);
        stp <= 1'h1;
        @(posedge clk);
        idle(4);
        chk(stop_m, 1'h1);
        chk(irq, 1'h1);
        w(`WDG_ADDR_MASK, 8'h00);
        idle(3);
        chk(irq, 1'h0);
        wake <= 1'h1;
        @(posedge clk);
        idle(3);
        chk(stop_m, 1'h0);
        w(`WDG_ADDR_STATUS, 8'h04);
        r(`WDG_ADDR_STATUS, 8'h00);
        w(`WDG_ADDR_COUNT, 8'hFF);
        w(`WDG_ADDR_COUNT, 8'hFE);
        r(`WDG_ADDR_COUNT, 8'hFF);
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            w(`WDG_ADDR_COUNT, {v[7:3], 3'h7});
            r(`WDG_ADDR_COUNT, {v[7:3], 3'h7});
        end
        idle(1);
        chk(chip_rst, 1'h0);
        pb0_low <= 1'h1;
        idle(3);
        stp <= 1'h1;
        @(posedge clk);
        idle(3);
        chk(stop_m, 1'h0);
        wake <= 1'h1;
        @(posedge clk);
        pb0_low <= 1'h0;
        idle(3);
        // a count two steps from expiry proves the freeze
        w(`WDG_ADDR_COUNT, 8'h83);
        stp <= 1'h1;
        wr <= 1'h0;
        @(posedge clk);
        idle(20);
        chk(chip_rst, 1'h0);
        chk(stop_m, 1'h1);
        wake <= 1'h1;
        @(posedge clk);
        idle(1);
        wait_rst(f);
        chk(f, 1'h1);
        r(`WDG_ADDR_COUNT, `WDG_RST_COUNT);
        // timeout event and the earlier freeze both stay recorded
        r(`WDG_ADDR_STATUS, 8'h05);
        w(`WDG_ADDR_COUNT, 8'h03);
        idle(1);
        wait_rst(f);
        chk(f, 1'h1);
        w(`WDG_ADDR_COUNT, 8'hFF);
        w(`WDG_ADDR_COUNT, 8'hFD);
        idle(1);
        wait_rst(f);
        chk(f, 1'h1);
        wrap_up();
    end
endmodule : wdg_core_tb_top
